//--- core/iew_irq_sleep.sv
/*
 * interrupt enable, timer2 flag merging, source gating, idle and
 * power-down control of an 8-bit controller core.
 * assumes hclk stands for the oscillator; osc_run tells the clock gate
 * to stop it. timer sources come as single-cycle pulses from same-clock timers,
 * serial_irq as a same-clock level, and the external lines as asynchronous pins.
 */
// Behaviour
// - six sources: two external, three timers, serial
// - each source gated by own enable bit
// - global enable blocks all acknowledgement
// - enable bits: t2=5,s=4,t1=3,x1=2,t0=1,x0=0
// - timer2 request is overflow OR external flag
// - vectoring never clears timer2 flags
// - timer0/1 flags set state5_phase2, sampled next cycle
// - clock-out rollovers raise no request
// - idle stops cpu, peripherals and registers keep
// - idle ends on enabled request or reset
// - reset from idle: ram writes blocked two cycles
// - power-down stops oscillator, registers retained
// - power-down exits on reset or ext0 request
// - reset from power-down keeps ram, resets ie, mask and timer2 flags
// - strobes high in idle, low in power-down
module iew_irq_sleep #(
   parameter int OSC_STABLE_CYCLES = iew_pkg::OSC_STABLE_DEF
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // interrupt sources
   input  wire logic        ext_irq_line_0,
   input  wire logic        ext_irq_line_1,
   input  wire logic        timer0_ovf,
   input  wire logic        timer1_ovf,
   input  wire logic        timer2_ovf,
   input  wire logic        timer2_ext_evt,
   input  wire logic        timer2_clkout_mode,
   input  wire logic        serial_irq,
   // cpu side
   input  wire logic        cpu_ack,
   input  wire logic [2:0]  cpu_ack_src,
   input  wire logic        reset_pin,
   output logic             irq_req,
   output logic [2:0]       irq_src,
   output logic             cpu_run,
   output logic             ram_wr_inhibit,
   output logic             osc_run,
   // pin state and interrupt
   output logic             addr_latch_strobe,
   output logic             program_store_strobe,
   output logic             port0_float,
   output logic             port2_addr,
   output logic             irq
);
   localparam int PHW = $clog2(iew_pkg::OSC_PER_MC);
   localparam int STW = $clog2(OSC_STABLE_CYCLES + 1);

   // all state of the block
   typedef struct packed {
      logic [7:0]          ie;          // interrupt_enable_reg
      logic                tf2;         // timer2_overflow_flag
      logic                timer2_external_flag;        // timer2_external_flag
      logic                tf0;         // timer0_overflow_flag
      logic                tf1;         // timer1_overflow_flag
      logic                tf0_smp;     // tf0 as polled by interrupt logic
      logic                tf1_smp;     // tf1 as polled by interrupt logic
      logic                t0_pend;     // overflow waiting for state5_phase2
      logic                t1_pend;
      logic                t2_pend;     // overflow waiting for state2_phase2
      logic [1:0]          x0_sync;     // ext line 0 synchroniser
      logic [1:0]          x1_sync;
      logic [1:0]          rp_sync;     // reset pin synchroniser
      logic [PHW-1:0]      phase;       // oscillator period in machine cycle
      iew_pkg::iew_pstate_t pst;
      logic                xmem;        // executing from external memory
      logic [1:0]          inh_mc;      // ram inhibit machine cycles elapsed
      logic [STW-1:0]      stab;        // oscillator settle count
      logic [2:0]          stat;
      logic [2:0]          mask;
      logic                ap_wr;       // latched write data phase
      logic                ap_rd;
      logic [7:0]          ap_ofs;
      logic [31:0]         rdata;
      logic                irq_req;
      logic [2:0]          irq_src;
      logic                cpu_run;
      logic                ram_inh;
      logic                osc_run;
      logic                ale;
      logic                pse;
      logic                p0f;
      logic                p2a;
      logic                irq;
   } iew_state_t;

   iew_state_t st;
   iew_state_t next_st;

   // read mux for one register offset
   function automatic logic [31:0] rd_mux(input iew_state_t s, input logic [7:0] ofs);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (ofs == iew_pkg::OFS_IE)
         v[7:0] = s.ie & 8'hBF;
      else if (ofs == iew_pkg::OFS_FLAGS)
         v[5:0] = {s.tf1_smp, s.tf0_smp, s.x1_sync[1], s.x0_sync[1], s.timer2_external_flag, s.tf2};
      else if (ofs == iew_pkg::OFS_PWR)
         v[4:0] = {s.pst, s.xmem, s.pst == iew_pkg::IEW_PDOWN, s.pst == iew_pkg::IEW_IDLE};
      else if (ofs == iew_pkg::OFS_STAT)
         v[2:0] = s.stat;
      else if (ofs == iew_pkg::OFS_MASK)
         v[2:0] = s.mask;
      return v;
   endfunction

   // next state
   always_comb
   begin
      logic [5:0] req;
      logic       wr;
      logic       t2_set;
      logic       mc_end;
      logic [2:0] ev;
      logic [2:0] src;
      logic       any;
      next_st = st;
      req = 6'h00;
      ev = 3'h0;
      src = 3'h0;
      any = 1'b0;
      wr = st.ap_wr;
      mc_end = (st.phase == PHW'(iew_pkg::OSC_PER_MC - 1));
      // synchronisers for asynchronous pins
      next_st.x0_sync = {st.x0_sync[0], ~ext_irq_line_0};
      next_st.x1_sync = {st.x1_sync[0], ~ext_irq_line_1};
      next_st.rp_sync = {st.rp_sync[0], reset_pin};
      // machine cycle phase; frozen while the oscillator is stopped
      if (st.osc_run)
         next_st.phase = mc_end ? '0 : st.phase + 1'b1;
      // acknowledged timer0/1 flags clear; timer2 flags never do
      // the clear comes first so that a flag set in the same cycle wins
      if (cpu_ack && cpu_ack_src == 3'h1)
      begin
         next_st.tf0 = 1'b0;
         next_st.tf0_smp = 1'b0;
      end
      if (cpu_ack && cpu_ack_src == 3'h3)
      begin
         next_st.tf1 = 1'b0;
         next_st.tf1_smp = 1'b0;
      end
      // timer0/1 flags set at state5_phase2, polled in the next machine cycle
      next_st.t0_pend = st.t0_pend | timer0_ovf;
      next_st.t1_pend = st.t1_pend | timer1_ovf;
      if (st.phase == PHW'(iew_pkg::PH_STATE5_PHASE2))
      begin
         next_st.tf0 = next_st.tf0 | st.t0_pend;
         next_st.tf1 = next_st.tf1 | st.t1_pend;
         next_st.t0_pend = timer0_ovf;
         next_st.t1_pend = timer1_ovf;
      end
      // poll sees the flag after any acknowledge of this cycle
      if (mc_end)
      begin
         next_st.tf0_smp = next_st.tf0;
         next_st.tf1_smp = next_st.tf1;
      end
      // timer2 overflow; clock-out rollovers dropped
      next_st.t2_pend = st.t2_pend | (timer2_ovf & ~timer2_clkout_mode);
      t2_set = st.phase == PHW'(iew_pkg::PH_STATE2_PHASE2) && st.t2_pend;
      if (st.phase == PHW'(iew_pkg::PH_STATE2_PHASE2))
         next_st.t2_pend = timer2_ovf & ~timer2_clkout_mode;
      // gated requests, priority by bit order
      req[iew_pkg::BIT_EX0] = st.x0_sync[1] & st.ie[iew_pkg::BIT_EX0];
      req[iew_pkg::BIT_ET0] = st.tf0_smp & st.ie[iew_pkg::BIT_ET0];
      req[iew_pkg::BIT_EX1] = st.x1_sync[1] & st.ie[iew_pkg::BIT_EX1];
      req[iew_pkg::BIT_ET1] = st.tf1_smp & st.ie[iew_pkg::BIT_ET1];
      req[iew_pkg::BIT_ES]  = serial_irq & st.ie[iew_pkg::BIT_ES];
      req[iew_pkg::BIT_ET2] = (st.tf2 | st.timer2_external_flag) & st.ie[iew_pkg::BIT_ET2];
      for (int i = 5; i >= 0; i--)
         if (req[i])
            src = 3'(i);
      any = (|req) & st.ie[iew_pkg::BIT_EA];
      next_st.irq_req = any & (st.pst == iew_pkg::IEW_RUN);
      next_st.irq_src = src;
      // power state machine
      next_st.ram_inh = 1'b0;
      case (st.pst)
         iew_pkg::IEW_RUN:
         begin
            next_st.cpu_run = 1'b1;
            next_st.osc_run = 1'b1;
            next_st.inh_mc = '0;
         end
         iew_pkg::IEW_IDLE:
         begin
            next_st.cpu_run = 1'b0;
            if (any)
            begin
               next_st.pst = iew_pkg::IEW_RUN;
               ev[iew_pkg::BIT_S_WAKE_IDLE] = 1'b1;
            end
            else if (st.rp_sync[1])
            begin
               // run on up to two machine cycles with ram writes blocked
               next_st.cpu_run = 1'b1;
               next_st.ram_inh = 1'b1;
               if (mc_end)
                  next_st.inh_mc = st.inh_mc + 1'b1;
               if (mc_end && st.inh_mc == 2'(iew_pkg::IDLE_RST_MC - 1))
               begin
                  next_st = '0;
                  next_st.ie = iew_pkg::RST_IE;
                  next_st.osc_run = 1'b1;
                  next_st.pst = iew_pkg::IEW_RUN;
               end
            end
         end
         iew_pkg::IEW_PDOWN:
         begin
            next_st.cpu_run = 1'b0;
            next_st.osc_run = 1'b0;
            if (st.rp_sync[1])
            begin
               next_st.pst = iew_pkg::IEW_WARM;
               next_st.stab = '0;
               next_st.osc_run = 1'b1;
            end
            else if (st.x0_sync[1] & st.ie[iew_pkg::BIT_EX0] & st.ie[iew_pkg::BIT_EA])
            begin
               next_st.pst = iew_pkg::IEW_WARM;
               next_st.stab = '0;
               next_st.osc_run = 1'b1;
               ev[iew_pkg::BIT_S_WAKE_PD] = 1'b1;
            end
         end
         default:
         begin
            // oscillator settling; cpu held until stable
            next_st.cpu_run = 1'b0;
            next_st.stab = st.stab + 1'b1;
            if (st.stab == STW'(OSC_STABLE_CYCLES - 1))
            begin
               next_st.pst = iew_pkg::IEW_RUN;
               if (st.rp_sync[1])
               begin
                  // enable, mask and timer2 flag reset, ram untouched
                  next_st.ie = iew_pkg::RST_IE;
                  next_st.tf2 = 1'b0;
                  next_st.timer2_external_flag = 1'b0;
                  next_st.mask = iew_pkg::RST_MASK;
               end
            end
         end
      endcase
      if (cpu_ack && st.ie[iew_pkg::BIT_EA])
         ev[iew_pkg::BIT_S_ACK] = 1'b1;
      // pin states per power state
      next_st.ale = (next_st.pst != iew_pkg::IEW_PDOWN);
      next_st.pse = (next_st.pst != iew_pkg::IEW_PDOWN);
      next_st.p0f = st.xmem && (next_st.pst == iew_pkg::IEW_IDLE
                                || next_st.pst == iew_pkg::IEW_PDOWN);
      next_st.p2a = st.xmem && (next_st.pst == iew_pkg::IEW_IDLE);
      // bus address phase capture
      next_st.ap_wr = hsel & hready & htrans[1] & hwrite;
      next_st.ap_rd = hsel & hready & htrans[1] & ~hwrite;
      if (hsel & hready & htrans[1])
         next_st.ap_ofs = haddr[7:0];
      if (hsel & hready & htrans[1] & ~hwrite)
         next_st.rdata = rd_mux(st, haddr[7:0]);
      // register writes
      if (wr)
      begin
         if (st.ap_ofs == iew_pkg::OFS_IE)
            next_st.ie = hwdata[7:0] & 8'hBF;
         else if (st.ap_ofs == iew_pkg::OFS_FLAGS)
         begin
            // software clears timer2 flags itself
            next_st.tf2 = hwdata[iew_pkg::BIT_TF2];
            next_st.timer2_external_flag = hwdata[iew_pkg::BIT_TIMER2_EXTERNAL_FLAG];
         end
         else if (st.ap_ofs == iew_pkg::OFS_PWR)
         begin
            next_st.xmem = hwdata[iew_pkg::BIT_XMEM];
            if (st.pst == iew_pkg::IEW_RUN && hwdata[iew_pkg::BIT_PD])
               next_st.pst = iew_pkg::IEW_PDOWN;
            else if (st.pst == iew_pkg::IEW_RUN && hwdata[iew_pkg::BIT_IDL])
               next_st.pst = iew_pkg::IEW_IDLE;
         end
         else if (st.ap_ofs == iew_pkg::OFS_STAT)
            next_st.stat = st.stat & ~hwdata[2:0];
         else if (st.ap_ofs == iew_pkg::OFS_MASK)
            next_st.mask = hwdata[2:0];
      end
      // hardware sets win over software clears
      if (t2_set)
         next_st.tf2 = 1'b1;
      if (timer2_ext_evt)
         next_st.timer2_external_flag = 1'b1;
      next_st.stat = next_st.stat | ev;
      next_st.irq = |(next_st.stat & next_st.mask);
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st <= '0;
         st.ie <= iew_pkg::RST_IE;
         st.stat <= iew_pkg::RST_STAT;
         st.mask <= iew_pkg::RST_MASK;
         st.pst <= iew_pkg::IEW_RUN;
         st.cpu_run <= 1'b1;
         st.osc_run <= 1'b1;
         st.ale <= 1'b1;
         st.pse <= 1'b1;
      end
      else
         st <= next_st;
   end

   // outputs straight from state; hreadyout and hresp tied constant
   assign hrdata = st.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq_req = st.irq_req;
   assign irq_src = st.irq_src;
   assign cpu_run = st.cpu_run;
   assign ram_wr_inhibit = st.ram_inh;
   assign osc_run = st.osc_run;
   assign addr_latch_strobe = st.ale;
   assign program_store_strobe = st.pse;
   assign port0_float = st.p0f;
   assign port2_addr = st.p2a;
   assign irq = st.irq;
endmodule

//--- core/iew_pkg.sv
/*
 * package for the interrupt enable and sleep/wake block: register offsets,
 * enable bit positions, reset values, power states and timing counts.
 * assumes a 32-bit ahb-lite bus with word-aligned registers.
 */
package iew_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_IE     = 8'h00;   // interrupt_enable_reg
   localparam logic [7:0] OFS_FLAGS  = 8'h04;   // timer2 flags and pending sources
   localparam logic [7:0] OFS_PWR    = 8'h08;   // power control and state
   localparam logic [7:0] OFS_STAT   = 8'h0C;   // sticky event status, w1c
   localparam logic [7:0] OFS_MASK   = 8'h10;   // event mask
   // interrupt_enable_reg bit positions
   localparam int BIT_EX0  = 0;
   localparam int BIT_ET0  = 1;
   localparam int BIT_EX1  = 2;
   localparam int BIT_ET1  = 3;
   localparam int BIT_ES   = 4;
   localparam int BIT_ET2  = 5;
   localparam int BIT_RSV  = 6;
   localparam int BIT_EA   = 7;
   // flags register bit positions
   localparam int BIT_TF2  = 0;
   localparam int BIT_TIMER2_EXTERNAL_FLAG = 1;
   // power register bit positions
   localparam int BIT_IDL  = 0;
   localparam int BIT_PD   = 1;
   localparam int BIT_XMEM = 2;
   // status bit positions
   localparam int BIT_S_WAKE_IDLE = 0;
   localparam int BIT_S_WAKE_PD   = 1;
   localparam int BIT_S_ACK       = 2;
   // reset values
   localparam logic [7:0] RST_IE   = 8'h00;
   localparam logic [2:0] RST_STAT = 3'h0;
   localparam logic [2:0] RST_MASK = 3'h0;
   // machine cycle: 12 oscillator periods per cycle
   localparam int OSC_PER_MC     = 12;
   localparam int PH_STATE2_PHASE2        = 3;   // oscillator period index of state2 phase2
   localparam int PH_STATE5_PHASE2        = 9;   // oscillator period index of state5 phase2
   localparam int IDLE_RST_MC    = 2;   // machine cycles of reset-from-idle window
   localparam int OSC_STABLE_DEF = 1024;
   // power states
   typedef enum logic [1:0] {IEW_RUN, IEW_IDLE, IEW_PDOWN, IEW_WARM} iew_pstate_t;
endpackage

//--- testbench/iew_cpu_model.sv
/* cpu core stand-in: vectors to pending requests after a set delay.
   assumes irq_req and irq_src stand until acknowledged. */
module iew_cpu_model (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // request in, delay setting
   input  wire logic       irq_req,
   input  wire logic [2:0] irq_src,
   input  wire logic [3:0] ack_dly,
   // acknowledge out
   output logic            cpu_ack,
   output logic [2:0]      cpu_ack_src
);
   logic [3:0] wait_cnt;  // cycles the request has waited
   // acknowledge only; timer2 flags are left to software
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wait_cnt    <= 4'h0;
         cpu_ack     <= 1'b0;
         cpu_ack_src <= 3'h0;
      end
      else
      begin
         cpu_ack     <= irq_req && !cpu_ack && (wait_cnt >= ack_dly);
         cpu_ack_src <= irq_src;
         wait_cnt    <= (irq_req && !cpu_ack) ? wait_cnt + 4'h1 : 4'h0;
      end
endmodule

//--- testbench/iew_irq_sleep_sva.sv
/* checker of the irq enable and sleep block, seen from its ports.
   assumes one bus master and hclk as the only clock. */
module iew_irq_sleep_sva (
   // clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   // sources and cpu side
   input wire logic        ext_irq_line_0,
   input wire logic        reset_pin,
   input wire logic        irq_req,
   input wire logic [2:0]  irq_src,
   input wire logic        cpu_run,
   input wire logic        osc_run,
   // pin state
   input wire logic        addr_latch_strobe,
   input wire logic        program_store_strobe,
   input wire logic        port0_float,
   input wire logic        port2_addr
);
   logic       ph_wr;   // enable register write data phase
   logic       ph_rd;   // enable register read data phase
   logic [7:0] ie_s;    // shadow of the enable register
   logic [3:0] ie_age;  // cycles since the shadow changed
   wire logic  tk = hsel && hready && htrans[1] && (haddr[7:0] == iew_pkg::OFS_IE);
   // shadow follows bus writes; a wake reset clears it
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         ph_wr  <= 1'b0;
         ph_rd  <= 1'b0;
         ie_s   <= iew_pkg::RST_IE;
         ie_age <= 4'h0;
      end
      else
      begin
         ph_wr  <= tk && hwrite;
         ph_rd  <= tk && !hwrite;
         ie_s   <= reset_pin ? 8'h00 : (ph_wr ? (hwdata[7:0] & 8'hBF) : ie_s);
         ie_age <= (reset_pin || ph_wr) ? 4'h0 : ((ie_age == 4'hF) ? ie_age : ie_age + 4'h1);
      end
   ea_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !ie_s[7] [*4] |-> !irq_req) else $error("request while globally disabled");
   src_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_req && ie_age > 4'h3 |-> ie_s[irq_src]) else $error("request from disabled source");
   src_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_req |-> irq_src <= 3'h5) else $error("request source out of range");
   ie_readback_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ph_rd |-> hrdata[7:0] == $past(ie_s)) else $error("enable register read mismatch");
   pd_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ext_irq_line_0 && !reset_pin) [*4] ##0 !osc_run |=> !osc_run)
      else $error("power-down left without cause");
   pd_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !osc_run |-> !addr_latch_strobe && !program_store_strobe)
      else $error("strobes high in power-down");
   strobe_pair_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_latch_strobe == program_store_strobe) else $error("strobes disagree");
   warm_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(osc_run) |-> !cpu_run [*4]) else $error("cpu ran before clock settled");
   port_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
      port2_addr |-> port0_float && addr_latch_strobe) else $error("idle port state wrong");
   run_req_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_req |-> cpu_run) else $error("request while cpu stopped");
endmodule

bind iew_irq_sleep iew_irq_sleep_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .ext_irq_line_0(ext_irq_line_0), .reset_pin(reset_pin),
   .irq_req(irq_req), .irq_src(irq_src), .cpu_run(cpu_run), .osc_run(osc_run),
   .addr_latch_strobe(addr_latch_strobe), .program_store_strobe(program_store_strobe),
   .port0_float(port0_float), .port2_addr(port2_addr));

//--- testbench/iew_irq_sleep_tb.sv
/* self-checking bench of the irq enable and sleep block with a cpu stand-in.
   assumes zero wait-state bus answers, taken at rising edges; other outputs are sampled at falling edges. */
module iew_irq_sleep_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         STAB = 8;                // short oscillator settle count
   localparam logic [7:0] A_IE = iew_pkg::OFS_IE;  // register addresses
   localparam logic [7:0] A_FL = iew_pkg::OFS_FLAGS;
   localparam logic [7:0] A_PW = iew_pkg::OFS_PWR;
   localparam logic [7:0] A_ST = iew_pkg::OFS_STAT;
   localparam logic [7:0] A_MK = iew_pkg::OFS_MASK;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, cpu_ack_src, irq_src;
   logic        ext_irq_line_0, ext_irq_line_1, timer0_ovf, timer1_ovf, timer2_ovf;
   logic        timer2_ext_evt, timer2_clkout_mode, serial_irq, cpu_ack, reset_pin;
   logic        irq_req, cpu_run, ram_wr_inhibit, osc_run, irq;
   logic        addr_latch_strobe, program_store_strobe, port0_float, port2_addr;
   logic [3:0]  ack_dly;                           // stand-in response delay
   int          n_fail, checks, cyc, i, s;
   wire logic       hready = hreadyout;            // single slave
   wire logic [4:0] obs = {irq, ram_wr_inhibit, osc_run, cpu_run, irq_req};
   iew_irq_sleep #(.OSC_STABLE_CYCLES(STAB)) uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_irq_line_0(ext_irq_line_0), .ext_irq_line_1(ext_irq_line_1),
      .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
      .timer2_ext_evt(timer2_ext_evt), .timer2_clkout_mode(timer2_clkout_mode),
      .serial_irq(serial_irq), .cpu_ack(cpu_ack), .cpu_ack_src(cpu_ack_src),
      .reset_pin(reset_pin), .irq_req(irq_req), .irq_src(irq_src), .cpu_run(cpu_run),
      .ram_wr_inhibit(ram_wr_inhibit), .osc_run(osc_run), .irq(irq),
      .addr_latch_strobe(addr_latch_strobe), .program_store_strobe(program_store_strobe),
      .port0_float(port0_float), .port2_addr(port2_addr));
   iew_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req), .irq_src(irq_src),
      .ack_dly(ack_dly), .cpu_ack(cpu_ack), .cpu_ack_src(cpu_ack_src));
   always #2.5 hclk = ~hclk;
   // compare one result, count it
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   // one single-word transfer; read data lands in rd
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // wait up to n cycles for an observed output to reach v, then compare
   task automatic wchk(input int k, input logic v, input int n);
      @(negedge hclk);
      while (obs[k] !== v && n-- > 0) @(negedge hclk);
      chk({31'h0, v}, {31'h0, obs[k]});
   endtask
   // drive source i: 0 ext0, 1 t0, 2 ext1, 3 t1, 4 serial, 5 t2 ovf, 6 t2 event
   task automatic fire(input int i, input logic on);
      @(posedge hclk);
      case (i)
         0: ext_irq_line_0 <= !on;
         1: timer0_ovf <= on;
         2: ext_irq_line_1 <= !on;
         3: timer1_ovf <= on;
         4: serial_irq <= on;
         5: timer2_ovf <= on;
         default: timer2_ext_evt <= on;
      endcase
      if (on && (i % 2 == 1 || i == 6))
         fire(i, 1'b0);
   endtask
   // closing report
   task automatic print_verdict();
      if (n_fail == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         print_verdict();
      end
   end
   initial
   begin
      void'($urandom(64));
      {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, timer0_ovf, timer1_ovf} = '0;
      {timer2_ovf, timer2_ext_evt, timer2_clkout_mode, serial_irq, reset_pin} = '0;
      {ext_irq_line_0, ext_irq_line_1, hsize, ack_dly} = {2'b11, 3'h2, 4'h0};
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(A_IE, 0, 0); chk(iew_pkg::RST_IE, rd); chk(0, hresp);
      for (i = 0; i < 4; i++)
      begin
         s = $urandom & 32'hFFFF_FFBF;
         bus(A_IE, 1, s); bus(A_IE, 0, 0); chk(s & 32'hBF, rd);
      end
      bus(8'h20, 1, 32'hFF); bus(8'h20, 0, 0); chk(0, rd);
      for (i = 0; i < 7; i++)
      begin
         s = (i > 5) ? 5 : i;
         ack_dly <= 4'($urandom % 8);
         bus(A_IE, 1, 32'h3F); fire(i, 1);
         repeat (40) @(negedge hclk); chk(0, irq_req);
         bus(A_IE, 1, 32'hBF & ~(32'h1 << s));
         repeat (30) @(negedge hclk); chk(0, irq_req);
         bus(A_IE, 1, 32'h80 | (32'h1 << s)); wchk(0, 1, 60);
         chk(s, irq_src);
         if (s == 5)
         begin
            repeat (20) @(negedge hclk); chk(1, irq_req);
            bus(A_FL, 0, 0); chk(1, rd[i - 5]);
            bus(A_FL, 1, 0);
         end
         if (i % 2 == 0 && i < 6)
            fire(i, 0);
         wchk(0, 0, 60);
      end
      timer2_clkout_mode <= 1'b1; bus(A_IE, 1, 32'hA0); fire(5, 1);
      repeat (40) @(negedge hclk); chk(0, irq_req);
      timer2_clkout_mode <= 1'b0; bus(A_MK, 1, 3); bus(A_IE, 1, 32'h90); bus(A_PW, 1, 5);
      wchk(1, 0, 20); chk(1, addr_latch_strobe); chk(1, program_store_strobe);
      chk(3, {port0_float, port2_addr}); bus(A_IE, 0, 0); chk(32'h90, rd);
      fire(4, 1); wchk(1, 1, 60); fire(4, 0); wchk(4, 1, 20);
      bus(A_MK, 1, 0); wchk(4, 0, 10); bus(A_MK, 1, 3); bus(A_ST, 1, 3); wchk(4, 0, 10);
      bus(A_ST, 0, 0); chk(0, rd & 3);
      bus(A_PW, 1, 1); wchk(1, 0, 20); reset_pin <= 1'b1; // no port write follows
      wchk(3, 1, 40); chk(1, cpu_run);
      repeat (40) @(posedge hclk);
      reset_pin <= 1'b0; wchk(3, 0, 40);
      bus(A_IE, 1, 32'h81); bus(A_PW, 1, 6); wchk(2, 0, 20);
      chk(2, {addr_latch_strobe, port0_float, port2_addr});
      fire(1, 1); repeat (30) @(negedge hclk); chk(0, osc_run);
      fire(0, 1); wchk(2, 1, 60); chk(0, cpu_run); wchk(1, 1, STAB + 40);
      fire(0, 0); bus(A_IE, 0, 0); chk(32'h81, rd);
      bus(A_PW, 1, 2); wchk(2, 0, 20); reset_pin <= 1'b1; wchk(2, 1, 40);
      wchk(1, 1, STAB + 60); reset_pin <= 1'b0; bus(A_IE, 0, 0); chk(0, rd);
      print_verdict();
   end
endmodule
